// ==== hdl/sahm_pkg.sv ====
// constants, types and register map of the servo alarm history monitor
// Notes on behaviour
// - history keeps fourteen newest alarms, viewable
// - a recorded alarm's code becomes history entry zero
// - codes 11,13,36,37,38,95 never recorded
// - display flashes while an alarm is active
// - encoder link faults coded 21, 23, 48
// - absolute encoder faults coded 40..47
// - alarm output valid about two seconds after power
// - control logic starts from control power alone
// - clear on incremental encoder shows error
// - power-on monitor item from default selection
// - reverse speed shown with minus, r/min
// - torque shown in percent of rated
// - control mode shown, one of four
// - regeneration ratio percent of detection level
// - overload ratio percent of rated load
// - analog beyond ten volts flagged inaccurate
package sahm_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int POR_MS = 2000;
  localparam int POR_CYC = POR_MS * (CLK_HZ / 1000);
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int HIST_DEPTH = 14;
  localparam int NUM_CAUSE = 27;
  localparam int PCT_FULL = 100;
  localparam logic [15:0] ANALOG_LIMIT_MV = 16'h2710;
  // fault input index to alarm code, lowest index has priority
  localparam logic [6:0] CAUSE_CODE [NUM_CAUSE] = '{
    7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h12, 7'h15, 7'h17,
    7'h18, 7'h1A, 7'h1B, 7'h22, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28,
    7'h29, 7'h2A, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h30, 7'h31, 7'h5F};
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PARAM = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_HSEL = 8'h0C;
  localparam logic [7:0] REG_HDATA = 8'h10;
  localparam logic [7:0] REG_MON = 8'h14;
  localparam logic [7:0] REG_MSEL = 8'h18;
  localparam int CTRL_ALM_CLR = 0;
  localparam int CTRL_ABS_START = 1;
  localparam int CTRL_ERR_CLR = 2;
  localparam logic [3:0] PARAM_RST = 4'h0;
  localparam logic [1:0] ENC_KIND_ABS = 2'h1;
  localparam logic [1:0] USAGE_ABS_A = 2'h0;
  localparam logic [1:0] USAGE_ABS_B = 2'h2;
  localparam int ST_ACTIVE = 8;
  localparam int ST_SETTLED = 9;
  localparam int ST_ABS_ERR = 10;
  localparam int ST_ABS_WAIT = 11;
  localparam int MON_NEG = 16;
  localparam int MON_OVR = 17;
  typedef enum logic [3:0] {
    MON_SPEED = 4'h0,
    MON_TORQUE = 4'h1,
    MON_MODE = 4'h2,
    MON_REGEN = 4'h3,
    MON_LOAD = 4'h4,
    MON_ANALOG = 4'h5
  } sahm_mon_t;
  typedef enum logic [0:0] {
    ABS_IDLE = 1'b0,
    ABS_WAIT_PWR = 1'b1
  } sahm_abs_t;
endpackage

// ==== hdl/sahm_hist_if.sv ====
// carrier between the monitor core and its alarm history store
`timescale 1ns/1ns
`default_nettype none
interface sahm_hist_if;
  logic push;
  logic [6:0] push_code;
  logic [3:0] rd_idx;
  logic [6:0] rd_code;
  logic [3:0] count;
  modport mgr (output push, output push_code, output rd_idx, input rd_code, input count);
  modport store (input push, input push_code, input rd_idx, output rd_code, output count);
endinterface
`default_nettype wire

// ==== hdl/sahm_hist.sv ====
// alarm history store, newest entry at index zero
`timescale 1ns/1ns
`default_nettype none
module sahm_hist #(
  parameter int DEPTH = sahm_pkg::HIST_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  sahm_hist_if.store hist
);
  logic [6:0] mem_r [DEPTH];
  logic [6:0] mem_nxt [DEPTH];
  logic [3:0] count_r;
  logic [3:0] count_nxt;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_ent
      if (g == 0)
      begin : g_head
        assign mem_nxt[g] = hist.push ? hist.push_code : mem_r[g];
      end
      else
      begin : g_tail
        // oldest falls off the end
        assign mem_nxt[g] = hist.push ? mem_r[g-1] : mem_r[g];
      end
    end
  endgenerate

  always_comb
  begin
    count_nxt = count_r;
    if (hist.push && count_r != 4'(DEPTH))
      count_nxt = count_r + 4'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r <= 4'h0;
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= 7'h00;
    end
    else
    begin
      count_r <= count_nxt;
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= mem_nxt[i];
    end
  end

  // entries past the fill level read as zero
  assign hist.rd_code = (hist.rd_idx < count_r) ? mem_r[hist.rd_idx] : 7'h00;
  assign hist.count = count_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  hist_shift_a: assert property (hist.push |=> mem_r[DEPTH-1] == $past(mem_r[DEPTH-2]))
    else $error("history did not shift");
  hist_fill_a: assert property (count_r <= 4'(DEPTH))
    else $error("history count beyond depth");
  hist_full_c: cover property (hist.push && count_r == 4'(DEPTH));
endmodule
`default_nettype wire

// ==== hdl/sahm_top.sv ====
// servo supervisory core: alarms, history, flashing, power-on delay, monitor
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sahm_top #(
  parameter int POR_CYC = sahm_pkg::POR_CYC,
  parameter int FLASH_CYC = sahm_pkg::FLASH_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [sahm_pkg::NUM_CAUSE-1:0] fault_flags,
  input wire logic [3:0] default_display_select,
  input wire logic [1:0] control_mode,
  input wire logic [15:0] motor_speed_rpm,
  input wire logic [15:0] torque_cmd,
  input wire logic [15:0] rated_torque,
  input wire logic [15:0] regen_load,
  input wire logic [15:0] regen_level,
  input wire logic [15:0] load_val,
  input wire logic [15:0] rated_load,
  input wire logic [15:0] analog_mv,
  output logic fault_output_n,
  output logic display_flash,
  output logic encoder_clear
);
  logic rst_s1_r;
  logic rst_n;
  sahm_hist_if hist_if ();

  // control power alone releases reset; no main power term
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  sahm_hist u_hist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hist(hist_if)
  );

  function automatic logic [15:0] mag16(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [15:0] pct(input logic [15:0] num, input logic [15:0] den);
    logic [22:0] q;
    q = (den == 16'h0000) ? 23'h7FFFFF : (23'(num) * 23'(sahm_pkg::PCT_FULL)) / 23'(den);
    return (q > 23'h00FFFF) ? 16'hFFFF : q[15:0];
  endfunction

  function automatic logic recordable(input logic [6:0] c);
    return !(c == 7'h0B || c == 7'h0D || c == 7'h24 || c == 7'h25 ||
      c == 7'h26 || c == 7'h5F);
  endfunction

  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [3:0] param_r, param_nxt;
  logic [3:0] hsel_r, hsel_nxt;
  sahm_pkg::sahm_mon_t msel_r, msel_nxt;
  logic boot_r;
  logic alm_active_r, alm_active_nxt;
  logic [6:0] cur_code_r, cur_code_nxt;
  logic [31:0] por_cnt_r, por_cnt_nxt;
  logic settled_r, settled_nxt;
  logic [31:0] flash_cnt_r, flash_cnt_nxt;
  logic flash_r, flash_nxt;
  logic fout_r, fout_nxt;
  sahm_pkg::sahm_abs_t abs_st_r, abs_st_nxt;
  logic abs_err_r, abs_err_nxt;
  logic enc_clr_r, enc_clr_nxt;
  logic [17:0] mon_r, mon_nxt;
  logic push_r, push_nxt;

  logic access, wr_done, mapped, alm_new, flash_tick, enc_ok, start_wr;
  logic [6:0] cause_code;
  logic [15:0] mag;
  logic neg, ovr;

  assign access = psel && penable && !pready_r;
  // write lands on the edge where the master sees pready
  assign wr_done = psel && penable && pready_r && pwrite;
  assign mapped = (paddr == sahm_pkg::REG_CTRL) || (paddr == sahm_pkg::REG_PARAM) ||
    (paddr == sahm_pkg::REG_STATUS) || (paddr == sahm_pkg::REG_HSEL) ||
    (paddr == sahm_pkg::REG_HDATA) || (paddr == sahm_pkg::REG_MON) ||
    (paddr == sahm_pkg::REG_MSEL);
  assign start_wr = wr_done && paddr == sahm_pkg::REG_CTRL && pwdata[sahm_pkg::CTRL_ABS_START];
  assign enc_ok = param_r[3:2] == sahm_pkg::ENC_KIND_ABS &&
    (param_r[1:0] == sahm_pkg::USAGE_ABS_A || param_r[1:0] == sahm_pkg::USAGE_ABS_B);
  assign alm_new = !alm_active_r && (|fault_flags);
  assign flash_tick = flash_cnt_r == 32'(FLASH_CYC - 1);

  always_comb
  begin
    cause_code = 7'h00;
    for (int i = sahm_pkg::NUM_CAUSE - 1; i >= 0; i--)
      if (fault_flags[i])
        cause_code = sahm_pkg::CAUSE_CODE[i];
  end

  always_comb
  begin
    mag = 16'h0000;
    neg = 1'b0;
    ovr = 1'b0;
    case (msel_r)
      sahm_pkg::MON_SPEED:
      begin
        mag = mag16(motor_speed_rpm);
        neg = motor_speed_rpm[15];
      end
      sahm_pkg::MON_TORQUE:
      begin
        mag = pct(mag16(torque_cmd), rated_torque);
        neg = torque_cmd[15];
      end
      sahm_pkg::MON_MODE: mag = {14'h0000, control_mode};
      sahm_pkg::MON_REGEN: mag = pct(regen_load, regen_level);
      sahm_pkg::MON_LOAD: mag = pct(load_val, rated_load);
      sahm_pkg::MON_ANALOG:
      begin
        mag = mag16(analog_mv);
        neg = analog_mv[15];
        ovr = mag > sahm_pkg::ANALOG_LIMIT_MV;
      end
      default: mag = 16'h0000;
    endcase
  end

  always_comb
  begin
    prdata_nxt = prdata_r;
    pready_nxt = access;
    pslverr_nxt = access && !mapped;
    param_nxt = param_r;
    hsel_nxt = hsel_r;
    msel_nxt = msel_r;
    alm_active_nxt = alm_active_r;
    cur_code_nxt = cur_code_r;
    por_cnt_nxt = por_cnt_r;
    settled_nxt = settled_r;
    flash_cnt_nxt = flash_tick ? 32'h0000_0000 : flash_cnt_r + 32'h0000_0001;
    flash_nxt = flash_r;
    abs_st_nxt = abs_st_r;
    abs_err_nxt = abs_err_r;
    enc_clr_nxt = 1'b0;
    push_nxt = 1'b0;
    mon_nxt = {ovr, neg && mag != 16'h0000, mag};
    if (access)
    begin
      case (paddr)
        sahm_pkg::REG_PARAM: prdata_nxt = {28'h0000000, param_r};
        sahm_pkg::REG_STATUS:
          prdata_nxt = {16'h0000, 4'(hist_if.count), abs_st_r == sahm_pkg::ABS_WAIT_PWR,
            abs_err_r, settled_r, alm_active_r, 1'b0, cur_code_r};
        sahm_pkg::REG_HSEL: prdata_nxt = {28'h0000000, hsel_r};
        sahm_pkg::REG_HDATA: prdata_nxt = {25'h0000000, hist_if.rd_code};
        sahm_pkg::REG_MON: prdata_nxt = {14'h0000, mon_r};
        sahm_pkg::REG_MSEL: prdata_nxt = {28'h0000000, msel_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_done)
    begin
      case (paddr)
        sahm_pkg::REG_PARAM: param_nxt = pwdata[3:0];
        sahm_pkg::REG_HSEL: hsel_nxt = pwdata[3:0];
        sahm_pkg::REG_MSEL: msel_nxt = sahm_pkg::sahm_mon_t'(pwdata[3:0]);
        default: hsel_nxt = hsel_r;
      endcase
    end
    if (!boot_r)
      msel_nxt = sahm_pkg::sahm_mon_t'(default_display_select);
    // clear only when no cause remains, so a fresh fault wins
    if (wr_done && paddr == sahm_pkg::REG_CTRL && pwdata[sahm_pkg::CTRL_ALM_CLR] &&
      !(|fault_flags))
    begin
      alm_active_nxt = 1'b0;
      cur_code_nxt = 7'h00;
    end
    if (alm_new)
    begin
      alm_active_nxt = 1'b1;
      cur_code_nxt = cause_code;
      push_nxt = recordable(cause_code);
    end
    if (!alm_active_r)
      flash_nxt = 1'b0;
    else if (flash_tick)
      flash_nxt = !flash_r;
    if (!settled_r)
    begin
      por_cnt_nxt = por_cnt_r + 32'h0000_0001;
      settled_nxt = por_cnt_r == 32'(POR_CYC - 1);
    end
    // host must not judge the output before settled
    fout_nxt = settled_r && !alm_active_nxt;
    if (wr_done && paddr == sahm_pkg::REG_CTRL && pwdata[sahm_pkg::CTRL_ERR_CLR])
      abs_err_nxt = 1'b0;
    case (abs_st_r)
      sahm_pkg::ABS_IDLE:
        if (start_wr)
        begin
          if (enc_ok)
          begin
            enc_clr_nxt = 1'b1;
            abs_st_nxt = sahm_pkg::ABS_WAIT_PWR;
          end
          else
            abs_err_nxt = 1'b1;
        end
      sahm_pkg::ABS_WAIT_PWR: abs_st_nxt = sahm_pkg::ABS_WAIT_PWR;
      default: abs_st_nxt = sahm_pkg::ABS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      param_r <= sahm_pkg::PARAM_RST;
      hsel_r <= 4'h0;
      msel_r <= sahm_pkg::MON_SPEED;
      boot_r <= 1'b0;
      alm_active_r <= 1'b0;
      cur_code_r <= 7'h00;
      por_cnt_r <= 32'h0000_0000;
      settled_r <= 1'b0;
      flash_cnt_r <= 32'h0000_0000;
      flash_r <= 1'b0;
      fout_r <= 1'b0;
      abs_st_r <= sahm_pkg::ABS_IDLE;
      abs_err_r <= 1'b0;
      enc_clr_r <= 1'b0;
      mon_r <= 18'h00000;
      push_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      param_r <= param_nxt;
      hsel_r <= hsel_nxt;
      msel_r <= msel_nxt;
      boot_r <= 1'b1;
      alm_active_r <= alm_active_nxt;
      cur_code_r <= cur_code_nxt;
      por_cnt_r <= por_cnt_nxt;
      settled_r <= settled_nxt;
      flash_cnt_r <= flash_cnt_nxt;
      flash_r <= flash_nxt;
      fout_r <= fout_nxt;
      abs_st_r <= abs_st_nxt;
      abs_err_r <= abs_err_nxt;
      enc_clr_r <= enc_clr_nxt;
      mon_r <= mon_nxt;
      push_r <= push_nxt;
    end
  end

  assign hist_if.push = push_r;
  assign hist_if.push_code = cur_code_r;
  assign hist_if.rd_idx = hsel_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fault_output_n = fout_r;
  assign display_flash = flash_r;
  assign encoder_clear = enc_clr_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  hist_push_a: assert property (alm_new && recordable(cause_code) |=> ##1
    (hist_if.rd_idx != 4'h0 || hist_if.rd_code == cur_code_r))
    else $error("history head differs from current code");
  no_record_a: assert property (push_r |-> recordable(cur_code_r))
    else $error("unrecorded code pushed to history");
  flash_run_a: assert property (alm_active_r && flash_tick |=> display_flash != $past(display_flash))
    else $error("display not flashing during alarm");
  por_hold_a: assert property (!settled_r |=> !fault_output_n)
    else $error("alarm output valid before settling");
  por_time_a: assert property ($rose(settled_r) |-> $past(por_cnt_r) == 32'(POR_CYC - 1))
    else $error("settling time wrong");
  abs_err_a: assert property (start_wr && !enc_ok && abs_st_r == sahm_pkg::ABS_IDLE
    |=> abs_err_r && !encoder_clear)
    else $error("clear on incremental encoder not refused");
  abs_go_a: assert property ($rose(encoder_clear) |-> $past(enc_ok) && $past(start_wr))
    else $error("encoder clear without valid setup");
  speed_sign_a: assert property (msel_r == sahm_pkg::MON_SPEED && motor_speed_rpm[15] &&
    $stable(msel_r) |=> mon_r[sahm_pkg::MON_NEG])
    else $error("reverse speed lacks minus sign");
  code_map_a: assert property (alm_new && fault_flags[7] && fault_flags[6:0] == 7'h00
    |=> cur_code_r == 7'h15)
    else $error("encoder fault code wrong");
  alarm_c: cover property (alm_new ##1 alm_active_r ##[1:20] !alm_active_r);
  abs_clear_c: cover property ($rose(encoder_clear));
  abs_err_c: cover property ($rose(abs_err_r));
  settle_c: cover property ($rose(settled_r));
endmodule
`default_nettype wire

// ==== verification/sahm_host_model.sv ====
// host controller model: samples the fault output once it has settled
`timescale 1ns/1ns
`default_nettype none
module sahm_host_model #(
  parameter int SETTLE_CYC = 60
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic fault_output_n,
  output logic run_cmd,
  output logic fault_seen
);
  int cnt;
  // operator never raises the run command in this bench
  assign run_cmd = 1'b0;
  always @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      cnt <= 0;
      fault_seen <= 1'b0;
    end
    else if (cnt < SETTLE_CYC)
      cnt <= cnt + 1;
    else if (fault_output_n === 1'b0)
      fault_seen <= 1'b1;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the servo alarm history monitor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int POR = 50;
  localparam int FL = 4;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [sahm_pkg::NUM_CAUSE-1:0] fault_flags;
  logic [3:0] dsel;
  logic [1:0] cmode;
  logic [15:0] spd, tq, rtq, rg, rgl, ld, rld, an;
  logic fault_output_n, display_flash, encoder_clear, run_cmd, fault_seen;
  int num_errors = 0;
  int cmp_count = 0;
  int pulses = 0;
  int codes [27] = '{11, 12, 13, 14, 15, 16, 18, 21, 23, 24, 26, 27, 34, 36, 37, 38, 39, 40,
    41, 42, 44, 45, 46, 47, 48, 49, 95};
  logic [31:0] mexp [6] = '{32'h000105DC, 32'h00010019, 32'h00000003, 32'h00000032,
    32'h00000096, 32'h00022EE0};
  int hist [$];

  sahm_top #(.POR_CYC(POR), .FLASH_CYC(FL)) sahm_top_i (.core_clk(core_clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_flags(fault_flags),
    .default_display_select(dsel), .control_mode(cmode), .motor_speed_rpm(spd),
    .torque_cmd(tq), .rated_torque(rtq), .regen_load(rg), .regen_level(rgl), .load_val(ld),
    .rated_load(rld), .analog_mv(an), .fault_output_n(fault_output_n),
    .display_flash(display_flash), .encoder_clear(encoder_clear));
  sahm_host_model #(.SETTLE_CYC(POR + 10)) sahm_host_model_i (.core_clk(core_clk),
    .resetn(resetn), .fault_output_n(fault_output_n), .run_cmd(run_cmd),
    .fault_seen(fault_seen));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (encoder_clear === 1'b1)
      pulses++;

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no answer time assumed; only the watchdog ends a hang
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string what);
    apb(1'b0, a, 32'h0);
    chk(what, e, rd & m);
  endtask

  task automatic alarm(input int i);
    int hi;
    hi = 0;
    @(posedge core_clk);
    fault_flags[i] <= 1'b1;
    repeat (10)
    begin
      @(posedge core_clk);
      hi += (display_flash === 1'b1);
    end
    chk("flashing", 32'h1, 32'(hi > 0 && hi < 10));
    chk("fault out", 32'h0, 32'(fault_output_n));
    rdchk(8'h08, 32'h17F, 32'h100 | 32'(codes[i]), "status code");
    if (!(codes[i] inside {11, 13, 36, 37, 38, 95}))
    begin
      hist.push_front(codes[i]);
      if (hist.size() > 14)
        void'(hist.pop_back());
    end
    apb(1'b1, 8'h0C, 32'h0);
    rdchk(8'h10, 32'h7F, 32'(hist.size() ? hist[0] : 0), "entry zero");
    fault_flags[i] <= 1'b0;
    apb(1'b1, 8'h00, 32'h1);
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    finish_test();
  end

  initial
  begin
    {resetn, psel, penable, pwrite, paddr, pwdata, fault_flags} = '0;
    dsel = 4'h1;
    cmode = 2'h3;
    spd = 16'hFA24;
    tq = 16'hFFCE;
    rtq = 16'h00C8;
    rg = 16'h001E;
    rgl = 16'h003C;
    ld = 16'h0096;
    rld = 16'h0064;
    an = 16'h2EE0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (POR - 10) @(posedge core_clk);
    chk("fault out early", 32'h0, 32'(fault_output_n));
    repeat (20) @(posedge core_clk);
    chk("fault out settled", 32'h1, 32'(fault_output_n));
    rdchk(8'h08, 32'h200, 32'h200, "settled bit");
    rdchk(8'h18, 32'hF, 32'h1, "power-on item");
    rdchk(8'h04, 32'hF, 32'h0, "param reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, 32'(perr));
    chk("host quiet", 32'h0, 32'(fault_seen));
    chk("run command off", 32'h0, 32'(run_cmd));
    $display("test reset done");
    for (int i = 0; i < 27; i++)
      alarm(i);
    repeat (2) @(posedge core_clk);
    chk("flash off", 32'h0, 32'(display_flash));
    chk("host saw fault", 32'h1, 32'(fault_seen));
    rdchk(8'h08, 32'hF100, 32'hE000, "history count");
    for (int i = 0; i < 15; i++)
    begin
      apb(1'b1, 8'h0C, 32'(i));
      rdchk(8'h10, 32'h7F, 32'(i < 14 ? hist[i] : 0), "history entry");
    end
    $display("test alarm history done");
    apb(1'b1, 8'h00, 32'h2);
    rdchk(8'h08, 32'hC00, 32'h400, "clear refused");
    chk("no clear pulse", 32'h0, 32'(pulses));
    apb(1'b1, 8'h00, 32'h4);
    rdchk(8'h08, 32'hC00, 32'h0, "error cleared");
    apb(1'b1, 8'h04, 32'h6);
    rdchk(8'h04, 32'hF, 32'h6, "param back");
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h00, 32'h2);
    rdchk(8'h08, 32'hC00, 32'h800, "clear waiting");
    chk("one clear pulse", 32'h1, 32'(pulses));
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge core_clk);
    rdchk(8'h08, 32'h800, 32'h0, "after power cycle");
    $display("test encoder clear done");
    for (int m = 0; m < 6; m++)
    begin
      apb(1'b1, 8'h18, 32'(m));
      rdchk(8'h14, 32'h3FFFF, mexp[m], "monitor value");
    end
    $display("test monitor done");
    finish_test();
  end
endmodule
`default_nettype wire
